// ---- src/rth_pkg.sv ----
// package of constants, register map and types for the room thermostat
`default_nettype none
package rth_pkg;
  // temperatures are signed, 0.1 degree units, 16 bits
  localparam int TEMP_W = 16;
  localparam int AW = 8;
  // register byte offsets
  localparam logic [AW-1:0] REG_CTRL = 8'h00;
  localparam logic [AW-1:0] REG_OFFSET = 8'h04;
  localparam logic [AW-1:0] REG_BUS_TEMP = 8'h08;
  localparam logic [AW-1:0] REG_WEIGHT = 8'h0C;
  localparam logic [AW-1:0] REG_HYST = 8'h10;
  localparam logic [AW-1:0] REG_TX_CFG = 8'h14;
  localparam logic [AW-1:0] REG_SENSOR = 8'h18;
  localparam logic [AW-1:0] REG_MEASURED = 8'h1C;
  localparam logic [AW-1:0] REG_STATUS = 8'h20;
  localparam logic [AW-1:0] REG_TX_DATA = 8'h24;
  localparam logic [AW-1:0] REG_SETPT_BASE = 8'h40;
  localparam logic [AW-1:0] REG_SETPT_LAST = 8'h5C;
  // control field positions
  localparam int CTRL_SENSOR_EN = 0;
  localparam int CTRL_SRC_LSB = 1;
  localparam int CTRL_ALG_LSB = 3;
  localparam int CTRL_HEAT_COOL = 6;
  localparam int CTRL_REVERSED = 7;
  localparam int CTRL_TERM_LSB = 8;
  localparam int CTRL_MODE_LSB = 10;
  localparam int CTRL_HC_EN = 12;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  // offset: steps of 0.5 degree, signed, -10..+10 steps
  localparam int OFS_W = 5;
  localparam logic signed [OFS_W-1:0] OFS_MIN = 5'sh16;
  localparam logic signed [OFS_W-1:0] OFS_MAX = 5'sh0A;
  localparam logic [TEMP_W-1:0] HALF_DEG = 16'h0005;
  // weight: 0..WEIGHT_FULL share of the built-in sensor
  localparam logic [7:0] WEIGHT_FULL = 8'h10;
  localparam logic [7:0] WEIGHT_RESET = 8'h08;
  localparam logic [TEMP_W-1:0] HYST_RESET = 16'h0005;
  localparam logic [TEMP_W-1:0] SETPT_RESET = 16'h00C8;
  // seconds tick
  localparam int CLK_HZ = 20_000_000;
  localparam int TICK_CYC = CLK_HZ;
  localparam int TICK_W = 25;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    RTH_SRC_SENSOR = 2'h0, RTH_SRC_BUS = 2'h1, RTH_SRC_MEAN = 2'h2
  } rth_src_e;
  typedef enum logic [2:0] {
    RTH_ALG_HYST = 3'h0, RTH_ALG_PI_ONOFF = 3'h1, RTH_ALG_PI_PWM = 3'h2,
    RTH_ALG_PI_CONT = 3'h3
  } rth_alg_e;
  typedef enum logic [1:0] {
    RTH_TERM_RADIATOR = 2'h0, RTH_TERM_ELECTRIC = 2'h1, RTH_TERM_FLOOR = 2'h2,
    RTH_TERM_CEILING = 2'h3
  } rth_term_e;
endpackage
`default_nettype wire

// ---- src/rth_setpt_mem.sv ----
// small memory of the eight setpoints, two registered read ports
`default_nettype none
module rth_setpt_mem (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  // write port
  input wire logic i_we,
  input wire logic [2:0] i_waddr,
  input wire logic [rth_pkg::TEMP_W-1:0] i_wdata,
  // read ports
  input wire logic [2:0] i_raddr_a,
  output logic [rth_pkg::TEMP_W-1:0] o_rdata_a,
  input wire logic [2:0] i_raddr_b,
  output logic [rth_pkg::TEMP_W-1:0] o_rdata_b
);
  import rth_pkg::*;
  logic [TEMP_W-1:0] mem [8];

  // -----------------------------------------------------------------
  // storage; every entry starts at the default setpoint
  // -----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int i = 0; i < 8; i++) begin
        mem[i] <= SETPT_RESET;
      end
    end else if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // registered reads: port a feeds the control loop, port b the bus
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata_a <= SETPT_RESET;
      o_rdata_b <= SETPT_RESET;
    end else begin
      o_rdata_a <= mem[i_raddr_a];
      o_rdata_b <= mem[i_raddr_b];
    end
  end
endmodule
`default_nettype wire

// ---- src/rth_top.sv ----
// room thermostat: sensor correction, reporting and two-point control
//
// Added by the designer: the placing of the registers and register access over AXI4-Lite.
`default_nettype none
// Functional notes
// - add half-degree correction, -5 to +5 degrees, to raw sensor value
// - report sensor value periodically and on a configured change
// - sensor value readable only while the sensor is enabled
// - room temperature from built-in sensor or bus value
// - optional weighted mean of sensor and bus values
// - algorithm selectable: hysteresis or PI variants; the code does not build PI and holds the outputs off for it
// - command derived from setpoint versus measured, sent periodic or on change; the code sends it on change only
// - normal heating: on below setpoint minus hysteresis, off at setpoint
// - normal cooling: on above setpoint plus hysteresis, off below setpoint
// - separate hysteresis widths for heating and cooling
// - reversed band placement only allowed for floor or ceiling panels
// - reversed heating: on below setpoint, off at setpoint plus hysteresis
// - reversed cooling: on above setpoint, off at setpoint minus hysteresis
// - one setpoint per operating mode, heating and cooling each
module rth_top (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  // sensor sample from logic on this clock
  input wire logic i_raw_valid,
  input wire logic [rth_pkg::TEMP_W-1:0] i_raw_temp,
  // axi4-lite write address and data
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [rth_pkg::AW-1:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  // axi4-lite write response
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // axi4-lite read
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [rth_pkg::AW-1:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  // bus objects toward actuators
  output logic o_cmd_send,
  output logic o_cmd_on,
  output logic o_sensor_send,
  output logic [rth_pkg::TEMP_W-1:0] o_sensor_value
);
  import rth_pkg::*;

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  function automatic logic [TEMP_W-1:0] abs_diff(input logic [TEMP_W-1:0] a,
                                                input logic [TEMP_W-1:0] b);
    logic signed [TEMP_W-1:0] d;
    d = $signed(a) - $signed(b);
    return d[TEMP_W-1] ? TEMP_W'(-d) : TEMP_W'(d);
  endfunction

  // -----------------------------------------------------------------
  // register state
  // -----------------------------------------------------------------
  logic [31:0] ctrl;
  logic signed [OFS_W-1:0] offset_steps;
  logic [TEMP_W-1:0] bus_temp;
  logic [7:0] weight;
  logic [TEMP_W-1:0] hyst_heat;
  logic [TEMP_W-1:0] hyst_cool;
  logic [15:0] tx_period;
  logic [TEMP_W-1:0] tx_delta;
  logic [TEMP_W-1:0] sensor_temp;
  logic [TEMP_W-1:0] measured_temp;
  logic heat_on;
  logic cool_on;
  logic [AW-1:0] aw_addr;
  logic aw_full;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_full;
  logic [TEMP_W-1:0] setpoint_temp;
  logic [TEMP_W-1:0] setpt_rd;

  wire logic do_write = aw_full && w_full && !o_bvalid;
  wire logic sensor_en = ctrl[CTRL_SENSOR_EN];
  wire rth_src_e src = rth_src_e'(ctrl[CTRL_SRC_LSB +: 2]);
  wire rth_alg_e alg = rth_alg_e'(ctrl[CTRL_ALG_LSB +: 3]);
  wire rth_term_e term = rth_term_e'(ctrl[CTRL_TERM_LSB +: 2]);
  wire logic cooling = ctrl[CTRL_HEAT_COOL];
  wire logic [1:0] op_mode = ctrl[CTRL_MODE_LSB +: 2];
  // panels only may use the reversed band
  wire logic reversed = ctrl[CTRL_REVERSED] &&
                        (term == RTH_TERM_FLOOR || term == RTH_TERM_CEILING);
  wire logic setpt_hit = aw_addr >= REG_SETPT_BASE && aw_addr <= REG_SETPT_LAST;
  wire logic [2:0] setpt_widx = 3'(aw_addr[4:2]);
  wire logic [31:0] strb_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};

  // -----------------------------------------------------------------
  // axi4-lite write channel: address and data latched in either order
  // -----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      o_bvalid <= 1'b0;
      o_bresp <= RESP_OKAY;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_full <= 1'b1;
        aw_addr <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_full <= 1'b1;
        w_data <= i_wdata;
        w_strb <= i_wstrb;
      end
      if (do_write) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp <= (aw_addr <= REG_HYST || aw_addr == REG_TX_CFG || setpt_hit) ?
                   RESP_OKAY : RESP_SLVERR;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // ready registered: one beat per write, low while holding a beat
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_awready <= 1'b0;
      o_wready <= 1'b0;
    end else begin
      o_awready <= !aw_full && !(i_awvalid && o_awready) && !o_bvalid;
      o_wready <= !w_full && !(i_wvalid && o_wready) && !o_bvalid;
    end
  end

  // -----------------------------------------------------------------
  // configuration registers
  // -----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ctrl <= CTRL_RESET;
      offset_steps <= '0;
      bus_temp <= '0;
      weight <= WEIGHT_RESET;
      hyst_heat <= HYST_RESET;
      hyst_cool <= HYST_RESET;
      tx_period <= '0;
      tx_delta <= '0;
    end else if (do_write) begin
      unique case (aw_addr)
        REG_CTRL: ctrl <= (ctrl & ~strb_mask) | (w_data & strb_mask);
        REG_OFFSET: begin
          // out-of-range corrections are clamped to the +/-5 degree span
          if ($signed(w_data[OFS_W-1:0]) > OFS_MAX) offset_steps <= OFS_MAX;
          else if ($signed(w_data[OFS_W-1:0]) < OFS_MIN) offset_steps <= OFS_MIN;
          else offset_steps <= $signed(w_data[OFS_W-1:0]);
        end
        REG_BUS_TEMP: bus_temp <= w_data[TEMP_W-1:0];
        REG_WEIGHT: weight <= (w_data[7:0] > WEIGHT_FULL) ? WEIGHT_FULL : w_data[7:0];
        REG_HYST: begin
          hyst_heat <= w_data[15:0];
          hyst_cool <= w_data[31:16];
        end
        REG_TX_CFG: begin
          tx_period <= w_data[15:0];
          tx_delta <= w_data[31:16];
        end
        default: ;
      endcase
    end
  end

  // setpoints: index = cooling*4 + mode
  rth_setpt_mem u_setpt (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_we(do_write && setpt_hit),
    .i_waddr(setpt_widx),
    .i_wdata(w_data[TEMP_W-1:0]),
    .i_raddr_a({cooling, op_mode}),
    .o_rdata_a(setpoint_temp),
    .i_raddr_b(3'(i_araddr[4:2])),
    .o_rdata_b(setpt_rd)
  );

  // -----------------------------------------------------------------
  // axi4-lite read channel; one cycle wait for the setpoint memory
  // -----------------------------------------------------------------
  logic rd_pend;
  logic [AW-1:0] rd_addr;
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_arready <= 1'b0;
      rd_pend <= 1'b0;
      rd_addr <= '0;
      o_rvalid <= 1'b0;
      o_rdata <= '0;
      o_rresp <= RESP_OKAY;
    end else begin
      o_arready <= !o_arready && !rd_pend && !o_rvalid && i_arvalid;
      if (i_arvalid && o_arready) begin
        rd_pend <= 1'b1;
        rd_addr <= i_araddr;
      end
      if (rd_pend) begin
        rd_pend <= 1'b0;
        o_rvalid <= 1'b1;
        o_rresp <= RESP_OKAY;
        unique case (rd_addr)
          REG_CTRL: o_rdata <= ctrl;
          REG_OFFSET: o_rdata <= 32'(offset_steps);
          REG_BUS_TEMP: o_rdata <= {16'h0000, bus_temp};
          REG_WEIGHT: o_rdata <= {24'h00_0000, weight};
          REG_HYST: o_rdata <= {hyst_cool, hyst_heat};
          REG_TX_CFG: o_rdata <= {tx_delta, tx_period};
          // disabled sensor offers no value
          REG_SENSOR: o_rdata <= sensor_en ? {16'h0000, sensor_temp} : '0;
          REG_MEASURED: o_rdata <= {16'h0000, measured_temp};
          REG_STATUS: o_rdata <= {29'h0, reversed, cool_on, heat_on};
          REG_TX_DATA: o_rdata <= {16'h0000, o_sensor_value};
          default: begin
            if (rd_addr >= REG_SETPT_BASE && rd_addr <= REG_SETPT_LAST) begin
              o_rdata <= {16'h0000, setpt_rd};
            end else begin
              o_rdata <= '0;
              o_rresp <= RESP_SLVERR;
            end
          end
        endcase
      end else if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

  // -----------------------------------------------------------------
  // sensor correction and source selection
  // -----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sensor_temp <= '0;
    end else if (i_raw_valid) begin
      sensor_temp <= TEMP_W'($signed(i_raw_temp) +
                     $signed(offset_steps) * $signed({1'b0, HALF_DEG}));
    end
  end

  // weighted mean: weight/16 from the sensor, rest from the bus value
  logic signed [TEMP_W+8:0] mean_sum;
  always_comb begin
    mean_sum = $signed(sensor_temp) * $signed({1'b0, weight}) +
               $signed(bus_temp) * $signed({1'b0, WEIGHT_FULL - weight});
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      measured_temp <= '0;
    end else begin
      unique case (src)
        RTH_SRC_SENSOR: measured_temp <= sensor_temp;
        RTH_SRC_BUS: measured_temp <= bus_temp;
        RTH_SRC_MEAN: measured_temp <= TEMP_W'(mean_sum >>> 4);
        default: measured_temp <= sensor_temp;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // two-point control
  // -----------------------------------------------------------------
  wire logic signed [TEMP_W-1:0] m = $signed(measured_temp);
  wire logic signed [TEMP_W-1:0] sp = $signed(setpoint_temp);
  wire logic signed [TEMP_W-1:0] sp_lo_h = sp - $signed(hyst_heat);
  wire logic signed [TEMP_W-1:0] sp_hi_h = sp + $signed(hyst_heat);
  wire logic signed [TEMP_W-1:0] sp_lo_c = sp - $signed(hyst_cool);
  wire logic signed [TEMP_W-1:0] sp_hi_c = sp + $signed(hyst_cool);

  // PI variants are not built here; they leave the outputs off
  logic next_heat_on;
  logic next_cool_on;
  always_comb begin
    next_heat_on = heat_on;
    next_cool_on = cool_on;
    if (alg != RTH_ALG_HYST || !ctrl[CTRL_HC_EN]) begin
      next_heat_on = 1'b0;
      next_cool_on = 1'b0;
    end else if (!cooling) begin
      next_cool_on = 1'b0;
      if (!reversed) begin
        if (m < sp_lo_h) next_heat_on = 1'b1;
        else if (m >= sp) next_heat_on = 1'b0;
      end else begin
        if (m < sp) next_heat_on = 1'b1;
        else if (m >= sp_hi_h) next_heat_on = 1'b0;
      end
    end else begin
      next_heat_on = 1'b0;
      if (!reversed) begin
        if (m > sp_hi_c) next_cool_on = 1'b1;
        else if (m < sp) next_cool_on = 1'b0;
      end else begin
        if (m > sp) next_cool_on = 1'b1;
        else if (m <= sp_lo_c) next_cool_on = 1'b0;
      end
    end
  end

  // one-second tick drives periodic repeats
  logic [TICK_W-1:0] tick_cnt;
  logic tick;
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (tick_cnt == TICK_W'(TICK_CYC - 1));
      tick_cnt <= (tick_cnt == TICK_W'(TICK_CYC - 1)) ? '0 : tick_cnt + 1'b1;
    end
  end

  // command object: sent on every state change
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      heat_on <= 1'b0;
      cool_on <= 1'b0;
      o_cmd_on <= 1'b0;
      o_cmd_send <= 1'b0;
    end else begin
      heat_on <= next_heat_on;
      cool_on <= next_cool_on;
      o_cmd_on <= next_heat_on | next_cool_on;
      o_cmd_send <= (next_heat_on != heat_on) || (next_cool_on != cool_on);
    end
  end

  // -----------------------------------------------------------------
  // sensor reporting: period in seconds, 0 disables; delta 0 disables
  // -----------------------------------------------------------------
  logic [15:0] per_cnt;
  wire logic per_due = tick && tx_period != 16'h0000 && per_cnt + 1'b1 >= tx_period;
  wire logic delta_due = tx_delta != '0 && abs_diff(sensor_temp, o_sensor_value) >= tx_delta;
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      per_cnt <= '0;
      o_sensor_send <= 1'b0;
      o_sensor_value <= '0;
    end else begin
      o_sensor_send <= 1'b0;
      if (tick) per_cnt <= per_due ? '0 : per_cnt + 1'b1;
      if (sensor_en && !o_sensor_send && (per_due || delta_due)) begin
        o_sensor_send <= 1'b1;
        o_sensor_value <= sensor_temp;
      end
    end
  end
endmodule
`default_nettype wire

// ---- bench/rth_props.sv ----
// checker of the thermostat port behaviour
`default_nettype none
module rth_props (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  // register bus
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic [1:0] o_bresp,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic o_rvalid,
  input wire logic i_rready,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0] o_rresp,
  // bus objects
  input wire logic o_cmd_send,
  input wire logic o_cmd_on,
  input wire logic o_sensor_send,
  input wire logic [rth_pkg::TEMP_W-1:0] o_sensor_value
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_reset_n);
  // --------------
  // objects toward the actuators
  // --------------
  cmd_pulse_a: assert property (o_cmd_send |=> !o_cmd_send)
    else $error("command pulse longer than one cycle");
  // the on level may only move together with a telegram
  cmd_cause_a: assert property ($changed(o_cmd_on) |-> ##[0:1] o_cmd_send)
    else $error("command level changed without a send");
  cmd_reason_a: assert property (o_cmd_send |-> $changed(o_cmd_on) ||
    $past(o_cmd_on) != $past(o_cmd_on, 2))
    else $error("command sent without a state change");
  sens_gap_a: assert property (o_sensor_send |=> !o_sensor_send)
    else $error("sensor reports closer than two cycles");
  sens_value_a: assert property ($changed(o_sensor_value) |-> o_sensor_send ||
    $past(o_sensor_send))
    else $error("reported value moved without a report");
  // --------------
  // register bus handshakes
  // --------------
  bresp_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped before taken");
  rdata_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata)
    && $stable(o_rresp))
    else $error("read data dropped before taken");
  rd_latency_a: assert property (i_arvalid && o_arready |-> ##1 !o_rvalid ##1 o_rvalid)
    else $error("read answer not two cycles after address");
  wr_resp_a: assert property (i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid)
    else $error("write response late");
  ar_pulse_a: assert property (o_arready |=> !o_arready)
    else $error("read address ready held");
endmodule
bind rth_top rth_props u_props (.i_sys_clk, .i_reset_n, .i_awvalid, .o_awready, .i_wvalid,
  .o_wready, .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready, .o_rvalid, .i_rready,
  .o_rdata, .o_rresp, .o_cmd_send, .o_cmd_on, .o_sensor_send, .o_sensor_value);
`default_nettype wire

// ---- bench/rth_knx_peer.sv ----
// actuator and display model on the far side of the bus objects
`default_nettype none
module rth_knx_peer (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  // objects from the thermostat
  input wire logic i_cmd_send,
  input wire logic i_cmd_on,
  input wire logic i_sensor_send,
  input wire logic [rth_pkg::TEMP_W-1:0] i_sensor_value,
  // what the far side took in
  output logic o_act_upd,
  output logic o_act_on,
  output logic o_rx_upd,
  output logic [rth_pkg::TEMP_W-1:0] o_rx_temp
);
  timeunit 1ns;
  timeprecision 1ns;
  import rth_pkg::*;
  // a telegram is only seen on its send pulse, the level between sends is ignored
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      {o_act_upd, o_act_on, o_rx_upd, o_rx_temp} <= '0;
    end else begin
      o_act_upd <= i_cmd_send;
      o_rx_upd <= i_sensor_send;
      if (i_cmd_send) o_act_on <= i_cmd_on;
      if (i_sensor_send) o_rx_temp <= i_sensor_value;
    end
  end
endmodule
`default_nettype wire

// ---- bench/rth_top_tb_top.sv ----
// self-checking bench for the room thermostat
`default_nettype none
module rth_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import rth_pkg::*;
  logic i_sys_clk, i_reset_n, i_raw_valid, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_cmd_send, o_cmd_on, o_sensor_send;
  logic [AW-1:0] i_awaddr, i_araddr;
  logic [31:0] i_wdata, o_rdata;
  logic [3:0] i_wstrb;
  logic [1:0] o_bresp, o_rresp, mode;
  logic [TEMP_W-1:0] i_raw_temp, o_sensor_value, rx_temp, seed, lv, r, hh, hc;
  logic [TEMP_W-1:0] spt [8];
  logic act_upd, act_on, rx_upd, cool, rev, st;
  logic [1:0] exp_b [$];
  logic [33:0] exp_r [$];
  logic exp_c [$];
  logic [15:0] exp_s [$];
  int mismatches, total_checks, n, ofsv;
  rth_top dut (.i_sys_clk, .i_reset_n, .i_raw_valid, .i_raw_temp, .i_awvalid, .o_awready,
    .i_awaddr, .i_wvalid, .o_wready, .i_wdata, .i_wstrb, .o_bvalid, .i_bready, .o_bresp,
    .i_arvalid, .o_arready, .i_araddr, .o_rvalid, .i_rready, .o_rdata, .o_rresp,
    .o_cmd_send, .o_cmd_on, .o_sensor_send, .o_sensor_value);
  rth_knx_peer peer (.i_sys_clk, .i_reset_n, .i_cmd_send(o_cmd_send), .i_cmd_on(o_cmd_on),
    .i_sensor_send(o_sensor_send), .i_sensor_value(o_sensor_value), .o_act_upd(act_upd),
    .o_act_on(act_on), .o_rx_upd(rx_upd), .o_rx_temp(rx_temp));
  // --------------
  // helpers
  // --------------
  initial begin
    i_sys_clk = 1'b0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("mismatches %0d total_checks %0d", mismatches, total_checks);
    if (mismatches == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic hang(input int k);
    if (k >= 200) begin
      mismatches++;
      complete_run();
    end
  endtask
  // ready follows the answer, so each answer stands a cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    int k;
    exp_b.push_back(e);
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    for (k = 0; k < 200; k++) begin
      @(posedge i_sys_clk);
      if (i_awvalid && o_awready) i_awvalid <= 1'b0;
      if (i_wvalid && o_wready) i_wvalid <= 1'b0;
      if (o_bvalid && i_bready) break;
      if (o_bvalid) i_bready <= 1'b1;
    end
    i_bready <= 1'b0;
    hang(k);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    int k;
    exp_r.push_back({e, d});
    i_araddr <= a;
    i_arvalid <= 1'b1;
    for (k = 0; k < 200; k++) begin
      @(posedge i_sys_clk);
      if (i_arvalid && o_arready) i_arvalid <= 1'b0;
      if (o_rvalid && i_rready) break;
      if (o_rvalid) i_rready <= 1'b1;
    end
    i_rready <= 1'b0;
    hang(k);
  endtask
  // eight cycles cover the measured lag plus the send
  task automatic temp(input logic [15:0] t);
    i_raw_temp <= t;
    i_raw_valid <= 1'b1;
    @(posedge i_sys_clk);
    i_raw_valid <= 1'b0;
    repeat (8) @(posedge i_sys_clk);
  endtask
  task automatic step(input logic [15:0] t);
    logic signed [15:0] sp, h, v;
    logic x;
    sp = spt[{cool, mode}];
    h = cool ? hc : hh;
    v = t;
    x = st;
    if (!cool && !rev) x = (v < sp - h) ? 1'b1 : (v >= sp) ? 1'b0 : st;
    if (cool && !rev) x = (v > sp + h) ? 1'b1 : (v < sp) ? 1'b0 : st;
    if (!cool && rev) x = (v < sp) ? 1'b1 : (v >= sp + h) ? 1'b0 : st;
    if (cool && rev) x = (v > sp) ? 1'b1 : (v <= sp - h) ? 1'b0 : st;
    if (x !== st) exp_c.push_back(x);
    st = x;
    temp(t);
  endtask
  // one control set-up, then one step per temperature
  task automatic phase(input logic c, q, input logic [1:0] tm, m, input logic [15:0] ts [6]);
    cool = c;
    rev = q && tm[1];
    mode = m;
    wr(REG_CTRL, 32'h1001 | {c, 6'h0} | {q, 7'h0} | {tm, 8'h0} | {m, 10'h0}, RESP_OKAY);
    foreach (ts[i]) step(ts[i]);
  endtask
  // --------------
  // result watcher
  // --------------
  always @(posedge i_sys_clk) begin
    if (o_bvalid && i_bready) chk(o_bresp, exp_b.size() ? exp_b.pop_front() : 2'bxx);
    if (o_rvalid && i_rready) chk({o_rresp, o_rdata}, exp_r.size() ? exp_r.pop_front() : 'x);
    if (act_upd) chk(act_on, exp_c.size() ? exp_c.pop_front() : 1'bx);
    if (rx_upd) chk(rx_temp, exp_s.size() ? exp_s.pop_front() : 'x);
  end
  // --------------
  // main sequence
  // --------------
  initial begin
    {i_reset_n, i_raw_valid, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = '0;
    {i_awaddr, i_araddr, i_wdata, i_raw_temp} = '0;
    i_wstrb = 4'hF;
    {mismatches, total_checks, cool, rev, st, mode} = '0;
    seed = 16'h07B7;
    spt = '{default: SETPT_RESET};
    hh = 16'h000A;
    hc = 16'h001E;
    repeat (6) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    rd(REG_CTRL, CTRL_RESET, RESP_OKAY);
    rd(REG_WEIGHT, {24'h0, WEIGHT_RESET}, RESP_OKAY);
    rd(REG_HYST, {HYST_RESET, HYST_RESET}, RESP_OKAY);
    rd(REG_SETPT_LAST, {16'h0, SETPT_RESET}, RESP_OKAY);
    rd(8'h30, 32'h0, RESP_SLVERR);
    wr(REG_SENSOR, 32'h1, RESP_SLVERR);
    wr(8'h34, 32'h1, RESP_SLVERR);
    wr(REG_TX_CFG, 32'h0, RESP_OKAY);
    wr(REG_HYST, {hc, hh}, RESP_OKAY);
    rd(REG_HYST, {hc, hh}, RESP_OKAY);
    wr(REG_SETPT_BASE + 8'h04, 32'h00FA, RESP_OKAY);
    spt[1] = 16'h00FA;
    temp(200);
    phase(0, 0, 2'h0, 2'h0, '{200, 190, 189, 195, 200, 200});
    phase(0, 1, 2'h0, 2'h0, '{200, 195, 189, 205, 200, 200});
    phase(0, 1, 2'h2, 2'h0, '{200, 199, 209, 210, 200, 200});
    phase(1, 0, 2'h0, 2'h0, '{200, 230, 231, 200, 199, 200});
    phase(1, 1, 2'h3, 2'h0, '{200, 201, 171, 170, 200, 200});
    exp_c.push_back(1'b1);
    st = 1'b1;
    phase(0, 0, 2'h0, 2'h1, '{200, 245, 250, 245, 250, 250});
    step(200);
    exp_c.push_back(1'b0);
    st = 1'b0;
    wr(REG_CTRL, 32'h1409, RESP_OKAY);
    lv = 16'h0;
    for (n = 0; n < 4; n++) begin
      ofsv = (n == 0) ? -10 : (n == 3) ? -3 : 10;
      seed = lfsr(seed);
      r = 16'h0064 + {8'h0, seed[7:0]};
      if (int'(r) + ofsv * 5 == int'(lv)) r++;
      wr(REG_TX_CFG, 32'h0, RESP_OKAY);
      wr(REG_OFFSET, (n == 2) ? 32'hC : 32'(ofsv), RESP_OKAY);
      temp(r);
      lv = 16'(int'(r) + ofsv * 5);
      exp_s.push_back(lv);
      wr(REG_TX_CFG, 32'h0001_0000, RESP_OKAY);
      rd(REG_SENSOR, {16'h0, lv}, RESP_OKAY);
    end
    wr(REG_TX_CFG, 32'h0005_0000, RESP_OKAY);
    temp(r + 16'h4);
    exp_s.push_back(lv + 16'h5);
    temp(r + 16'h5);
    wr(REG_CTRL, 32'h0, RESP_OKAY);
    temp(r + 16'h28);
    rd(REG_SENSOR, 32'h0, RESP_OKAY);
    wr(REG_TX_CFG, 32'h0, RESP_OKAY);
    wr(REG_OFFSET, 32'h0, RESP_OKAY);
    wr(REG_BUS_TEMP, 32'h0096, RESP_OKAY);
    wr(REG_CTRL, 32'h3, RESP_OKAY);
    temp(200);
    rd(REG_MEASURED, 32'h0096, RESP_OKAY);
    wr(REG_CTRL, 32'h5, RESP_OKAY);
    for (n = 0; n < 3; n++) begin
      wr(REG_WEIGHT, (n == 0) ? 32'h0 : (n == 1) ? 32'h8 : 32'h14, RESP_OKAY);
      temp(200);
      rd(REG_MEASURED, (n == 0) ? 32'h96 : (n == 1) ? 32'hAF : 32'hC8, RESP_OKAY);
    end
    repeat (10) @(posedge i_sys_clk);
    chk(34'(exp_c.size() + exp_s.size() + exp_b.size() + exp_r.size()), 34'h0);
    complete_run();
  end
endmodule
`default_nettype wire
